// ### src/mqs_pkg.sv
// Package for the multi-queue sequencing pair: queue geometry, serial
// load length, address fields and the controller register map.
// Assumes both ends and the bench share one clock, sys_clk.
package mqs_pkg;
  // ==========================================================
  // Queue geometry
  localparam int DATA_W = 36;
  localparam int NUM_Q = 4;
  localparam int Q_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 5'h10;
  localparam logic [CNT_W-1:0] AF_LEVEL = 5'h0C;
  // ==========================================================
  // Queue address: device number above, queue number below
  localparam int ADDR_W = 6;
  localparam int DEV_W = 3;
  localparam int QSEL_W = 3;
  localparam logic [QSEL_W-1:0] NULL_Q = 3'h7;
  // ==========================================================
  // Serial configuration stream length
  localparam int LOAD_HDR = 19;
  localparam int LOAD_PER_Q = 72;
  localparam int LOAD_CNT_W = 9;
  localparam logic [LOAD_CNT_W-1:0] LOAD_BITS = 9'(LOAD_HDR + LOAD_PER_Q * NUM_Q);
  // ==========================================================
  // Least read-clock cycles between read queue selections
  localparam logic [1:0] RD_SEL_GAP = 2'h2;
  // ==========================================================
  // Controller register map, byte addresses
  localparam int PADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_WQSEL = 8'h08;
  localparam logic [7:0] REG_RQSEL = 8'h0C;
  localparam logic [7:0] REG_WDATA = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_READ = 8'h18;
  localparam logic [7:0] REG_INT_STAT = 8'h1C;
  localparam logic [7:0] REG_INT_MASK = 8'h20;
  localparam logic [7:0] REG_SER_PAT = 8'h24;
  // CTRL bits
  localparam int CTRL_MRST = 0;
  localparam int CTRL_DFM = 1;
  localparam int CTRL_LOAD = 2;
  localparam int CTRL_OEN = 3;
  localparam int CTRL_DFS = 4;
  // Event bits, shared by STATUS-side interrupt registers
  localparam int EV_READY = 0;
  localparam int EV_VALID = 1;
  localparam int EV_AFULL = 2;
  localparam int EV_REFUSE = 3;
  localparam int EV_W = 4;
  // Device read-side queue change sequence
  typedef enum logic [1:0] {MQS_IDLE, MQS_OLD, MQS_NEW} mqs_sw_t;
endpackage

// ### src/mqs_if.sv
// Interface joining the controller end and the queue device end.
// Assumes a single device in the chain; three-state pins are split
// into value and enable; the controller reads both halves, and no wire is resolved.
`timescale 1ns/100ps
`default_nettype none
interface mqs_if;
  logic masterResetN;
  logic defaultModeSelect;
  logic defaultOffsetSelect;
  logic serialLoadEnableInN;
  logic serialDataIn;
  logic serialLoadEnableOutN;
  logic serialDataOut;
  logic wrSel;
  logic [mqs_pkg::ADDR_W-1:0] wrAddr;
  logic wenN;
  logic [mqs_pkg::DATA_W-1:0] wrData;
  logic rdSel;
  logic [mqs_pkg::ADDR_W-1:0] rdAddr;
  logic renN;
  logic outEnN;
  logic [mqs_pkg::DATA_W-1:0] rdData;
  logic rdDataOe;
  logic outputValidN;
  logic outputValidOe;
  logic almostFullN;
  logic almostFullOe;
  modport dev (
    input masterResetN, defaultModeSelect, defaultOffsetSelect, serialLoadEnableInN, serialDataIn,
    input wrSel, wrAddr, wenN, wrData, rdSel, rdAddr, renN, outEnN,
    output serialLoadEnableOutN, serialDataOut, rdData, rdDataOe, outputValidN, outputValidOe,
    output almostFullN, almostFullOe
  );
  modport ctl (
    output masterResetN, defaultModeSelect, defaultOffsetSelect, serialLoadEnableInN, serialDataIn,
    output wrSel, wrAddr, wenN, wrData, rdSel, rdAddr, renN, outEnN,
    input serialLoadEnableOutN, serialDataOut, rdData, rdDataOe, outputValidN, outputValidOe,
    input almostFullN, almostFullOe
  );
endinterface
`default_nettype wire

// ### src/mqs_device.sv
// Queue device end: four queues behind one write and one read port,
// serial configuration load with chain pass-through, fall-through read
// pipeline, output-valid and almost-full flags with expansion drive.
// Assumes the controller drives its pins from logic on sys_clk.
// Contract
// - After load, pass enable and data through
// - Low mode select at reset picks serial
// - Finished chain refuses further serial loads
// - Load is 19 plus 72 bits per queue
// - No port operation before configuration completes
// - First word reaches output one clock later
// - New queue word appears two cycles after select
// - Cycle after change pops one old word
// - Empty queue: valid high, word held
// - Read enable high holds word and pointers
// - Write into read-empty queue drives valid low
// - Owner drives bus when first word appears
// - Output enable gates the data bus driver only, asynchronously
// - Null queue acts as always empty
// - Two cycles between read queue selections
// - Almost-full falls two cycles after write
// - Almost-full follows new queue two cycles later
// - Unselected device floats its almost-full flag
`timescale 1ns/100ps
`default_nettype none
module mqs_device #(
  parameter logic [mqs_pkg::DEV_W-1:0] DEV_ID = 3'h0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  mqs_if.dev link
);
  // ==========================================================
  // Storage and state
  logic [mqs_pkg::DATA_W-1:0] mem [mqs_pkg::NUM_Q*mqs_pkg::Q_DEPTH];
  logic [mqs_pkg::PTR_W-1:0] wrPtr [mqs_pkg::NUM_Q];
  logic [mqs_pkg::PTR_W-1:0] rdPtr [mqs_pkg::NUM_Q];
  logic [mqs_pkg::CNT_W-1:0] count [mqs_pkg::NUM_Q];
  logic cfgDone;
  logic [mqs_pkg::LOAD_CNT_W-1:0] loadCnt;
  logic [1:0] wrQ;
  logic wrLive;
  logic [1:0] rdQ;
  logic rdLive;
  logic [1:0] prevQ;
  logic prevLive;
  logic rdOwn;
  logic rdDrive;
  mqs_pkg::mqs_sw_t swStage;
  logic [mqs_pkg::DATA_W-1:0] outWord;
  logic ovN;
  logic afPipe;
  logic afN;
  logic wrOwn;
  // ==========================================================
  // Combinational decode
  logic doWrite;
  logic want;
  logic [1:0] srcQ;
  logic srcLive;
  logic doPop;
  logic [mqs_pkg::NUM_Q-1:0] popVec;
  logic [mqs_pkg::NUM_Q-1:0] wrVec;
  logic [mqs_pkg::QSEL_W-1:0] wrSelQ;
  logic [mqs_pkg::QSEL_W-1:0] rdSelQ;

  assign wrSelQ = link.wrAddr[mqs_pkg::QSEL_W-1:0];
  assign rdSelQ = link.rdAddr[mqs_pkg::QSEL_W-1:0];

  // Writes only land once configured and owned; full queue drops them
  assign doWrite = cfgDone && !link.wenN && wrOwn && wrLive && count[wrQ] != mqs_pkg::DEPTH_CNT;

  // Source of the next output word, steered by the change sequence
  always_comb begin
    unique case (swStage)
      mqs_pkg::MQS_OLD: begin
        srcQ = prevQ;
        srcLive = prevLive;
        want = 1'b1;
      end
      mqs_pkg::MQS_NEW: begin
        srcQ = rdQ;
        srcLive = rdLive && rdOwn;
        want = 1'b1;
      end
      mqs_pkg::MQS_IDLE: begin
        srcQ = rdQ;
        srcLive = rdLive && rdOwn;
        want = !link.renN || ovN;
      end
    endcase
  end

  // Null queue or empty queue never pops
  assign doPop = cfgDone && want && srcLive && count[srcQ] != '0;

  // ==========================================================
  // Per-queue pointers and occupancy
  genvar gi;
  generate
    for (gi = 0; gi < mqs_pkg::NUM_Q; gi++) begin : g_q
      assign popVec[gi] = doPop && srcQ == 2'(gi);
      assign wrVec[gi] = doWrite && wrQ == 2'(gi);
      // Simultaneous write and pop leave the count unchanged
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          count[gi] <= '0;
          wrPtr[gi] <= '0;
          rdPtr[gi] <= '0;
        end else if (!link.masterResetN) begin
          count[gi] <= '0;
          wrPtr[gi] <= '0;
          rdPtr[gi] <= '0;
        end else begin
          count[gi] <= count[gi] + CNT_ONE(wrVec[gi]) - CNT_ONE(popVec[gi]);
          if (wrVec[gi]) begin
            wrPtr[gi] <= wrPtr[gi] + 1'b1;
          end
          if (popVec[gi]) begin
            rdPtr[gi] <= rdPtr[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  function automatic logic [mqs_pkg::CNT_W-1:0] CNT_ONE(input logic b);
    CNT_ONE = {{(mqs_pkg::CNT_W-1){1'b0}}, b};
  endfunction

  // Queue memory, no reset needed for data
  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[{wrQ, wrPtr[wrQ]}] <= link.wrData;
    end
  end

  // ==========================================================
  // Serial configuration load
  // Mode strap is caught while master reset is held, clocked
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgDone <= 1'b0;
      loadCnt <= '0;
    end else if (!link.masterResetN) begin
      cfgDone <= link.defaultModeSelect;
      loadCnt <= '0;
    end else if (!cfgDone && !link.serialLoadEnableInN) begin
      loadCnt <= loadCnt + 1'b1;
      if (loadCnt == mqs_pkg::LOAD_BITS - 1'b1) begin
        cfgDone <= 1'b1;
      end
    end
  end

  // Once loaded, later loads only pass through to the next device
  assign link.serialLoadEnableOutN = cfgDone ? link.serialLoadEnableInN : 1'b1;
  assign link.serialDataOut = cfgDone ? link.serialDataIn : 1'b0;

  // ==========================================================
  // Write queue selection and almost-full flag
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrQ <= '0;
      wrLive <= 1'b0;
      wrOwn <= 1'b0;
    end else if (cfgDone && link.wrSel) begin
      wrQ <= wrSelQ[1:0];
      wrLive <= wrSelQ < mqs_pkg::QSEL_W'(mqs_pkg::NUM_Q);
      wrOwn <= link.wrAddr[mqs_pkg::ADDR_W-1 -: mqs_pkg::DEV_W] == DEV_ID;
    end
  end

  // Two stages: write or queue change shows two edges later
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      afPipe <= 1'b1;
      afN <= 1'b1;
    end else begin
      afPipe <= !(wrLive && count[wrQ] >= mqs_pkg::AF_LEVEL);
      afN <= afPipe;
    end
  end

  assign link.almostFullN = afN;
  assign link.almostFullOe = wrOwn;

  // ==========================================================
  // Read queue selection and change sequence
  // A new select during the sequence restarts it; spacing is the
  // controller's duty
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdQ <= '0;
      rdLive <= 1'b0;
      rdOwn <= 1'b0;
      prevQ <= '0;
      prevLive <= 1'b0;
      swStage <= mqs_pkg::MQS_IDLE;
    end else if (cfgDone && link.rdSel) begin
      prevQ <= rdQ;
      prevLive <= rdLive && rdOwn;
      rdQ <= rdSelQ[1:0];
      rdLive <= rdSelQ < mqs_pkg::QSEL_W'(mqs_pkg::NUM_Q);
      rdOwn <= link.rdAddr[mqs_pkg::ADDR_W-1 -: mqs_pkg::DEV_W] == DEV_ID;
      swStage <= mqs_pkg::MQS_OLD;
    end else begin
      unique case (swStage)
        mqs_pkg::MQS_OLD: swStage <= mqs_pkg::MQS_NEW;
        mqs_pkg::MQS_NEW: swStage <= mqs_pkg::MQS_IDLE;
        mqs_pkg::MQS_IDLE: swStage <= mqs_pkg::MQS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Output register and valid flag
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      outWord <= '0;
      ovN <= 1'b1;
    end else if (!link.masterResetN) begin
      ovN <= 1'b1;
    end else if (doPop) begin
      outWord <= mem[{srcQ, rdPtr[srcQ]}];
      ovN <= 1'b0;
    end else if (want && swStage != mqs_pkg::MQS_OLD) begin
      ovN <= 1'b1;
    end
  end

  // Bus ownership swaps with the first word of the new queue
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdDrive <= 1'b0;
    end else if (swStage == mqs_pkg::MQS_NEW) begin
      rdDrive <= rdOwn;
    end
  end

  // Output enable is asynchronous and leaves register and flag alone
  assign link.rdData = outWord;
  assign link.rdDataOe = rdDrive && !link.outEnN;
  assign link.outputValidN = ovN;
  assign link.outputValidOe = rdDrive;
endmodule
`default_nettype wire

// ### src/mqs_ctrl.sv
// Controller end: an APB slave whose registers order master reset,
// serial load, queue selections, writes and reads on the device pins.
// Assumes the device shares sys_clk; rdData is sampled directly.
`timescale 1ns/100ps
`default_nettype none
module mqs_ctrl (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mqs_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  mqs_if.ctl link
);
  // ==========================================================
  // Registers and state
  logic [4:0] ctrl;
  logic [31:0] serPat;
  logic loadArmed;
  logic [mqs_pkg::LOAD_CNT_W-1:0] bitCnt;
  logic [1:0] rdGap;
  logic [mqs_pkg::EV_W-1:0] intStat;
  logic [mqs_pkg::EV_W-1:0] intMask;
  logic [mqs_pkg::EV_W-1:0] events;
  logic readyOld;
  logic ovOld;
  logic afOld;
  logic chainReady;
  logic acc;
  logic wr;
  logic portOp;
  logic mapped;

  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign chainReady = loadArmed && !link.serialLoadEnableOutN;
  assign portOp = wr && (paddr == mqs_pkg::REG_WQSEL || paddr == mqs_pkg::REG_RQSEL ||
                         paddr == mqs_pkg::REG_WDATA || paddr == mqs_pkg::REG_READ);
  // Read selects stall until the spacing has elapsed
  assign pready = !(psel && pwrite && paddr == mqs_pkg::REG_RQSEL && rdGap != '0);

  // ==========================================================
  // Software registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= 5'h01;
      serPat <= '0;
      intMask <= '0;
    end else if (wr) begin
      if (paddr == mqs_pkg::REG_CTRL) begin
        ctrl <= pwdata[4:0];
      end
      if (paddr == mqs_pkg::REG_SER_PAT) begin
        serPat <= pwdata;
      end
      if (paddr == mqs_pkg::REG_INT_MASK) begin
        intMask <= pwdata[mqs_pkg::EV_W-1:0];
      end
    end
  end

  assign link.masterResetN = !ctrl[mqs_pkg::CTRL_MRST];
  assign link.defaultModeSelect = ctrl[mqs_pkg::CTRL_DFM];
  assign link.defaultOffsetSelect = ctrl[mqs_pkg::CTRL_DFS];
  assign link.outEnN = ctrl[mqs_pkg::CTRL_OEN];

  // ==========================================================
  // Serial load: exact stream length, enable held low afterwards
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      loadArmed <= 1'b0;
      bitCnt <= '0;
    end else if (ctrl[mqs_pkg::CTRL_MRST]) begin
      loadArmed <= 1'b0;
      bitCnt <= '0;
    end else if (wr && paddr == mqs_pkg::REG_CTRL && pwdata[mqs_pkg::CTRL_LOAD] && !loadArmed) begin
      loadArmed <= 1'b1;
    end else if (loadArmed && bitCnt != mqs_pkg::LOAD_BITS) begin
      bitCnt <= bitCnt + 1'b1;
    end
  end

  assign link.serialLoadEnableInN = !loadArmed;
  assign link.serialDataIn = loadArmed && bitCnt != mqs_pkg::LOAD_BITS && serPat[bitCnt[4:0]];

  // ==========================================================
  // Port strobes, one cycle each, refused before configuration
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.wrSel <= 1'b0;
      link.rdSel <= 1'b0;
      link.wenN <= 1'b1;
      link.renN <= 1'b1;
      link.wrAddr <= '0;
      link.rdAddr <= '0;
      link.wrData <= '0;
    end else begin
      link.wrSel <= portOp && chainReady && paddr == mqs_pkg::REG_WQSEL;
      link.rdSel <= portOp && chainReady && paddr == mqs_pkg::REG_RQSEL;
      link.wenN <= !(portOp && chainReady && paddr == mqs_pkg::REG_WDATA);
      link.renN <= !(portOp && chainReady && paddr == mqs_pkg::REG_READ);
      if (portOp && paddr == mqs_pkg::REG_WQSEL) begin
        link.wrAddr <= pwdata[mqs_pkg::ADDR_W-1:0];
      end
      if (portOp && paddr == mqs_pkg::REG_RQSEL) begin
        link.rdAddr <= pwdata[mqs_pkg::ADDR_W-1:0];
      end
      if (portOp && paddr == mqs_pkg::REG_WDATA) begin
        link.wrData <= {4'h0, pwdata};
      end
    end
  end

  // Counts down the cycles left before another read select may go out
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdGap <= '0;
    end else if (link.rdSel) begin
      rdGap <= mqs_pkg::RD_SEL_GAP - 1'b1;
    end else if (portOp && chainReady && paddr == mqs_pkg::REG_RQSEL) begin
      rdGap <= mqs_pkg::RD_SEL_GAP;
    end else if (rdGap != '0) begin
      rdGap <= rdGap - 1'b1;
    end
  end

  // ==========================================================
  // Interrupts: sticky, read clears, a new event wins over the clear
  assign events = {portOp && !chainReady, !afOld ? 1'b0 : !link.almostFullN && link.almostFullOe,
                   ovOld && !link.outputValidN && link.outputValidOe, chainReady && !readyOld};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      intStat <= '0;
      readyOld <= 1'b0;
      ovOld <= 1'b1;
      afOld <= 1'b1;
    end else begin
      readyOld <= chainReady;
      ovOld <= link.outputValidN;
      afOld <= link.almostFullN;
      if (acc && !pwrite && paddr == mqs_pkg::REG_INT_STAT) begin
        intStat <= events;
      end else begin
        intStat <= intStat | events;
      end
    end
  end
  assign irq = |(intStat & intMask);

  // ==========================================================
  // Read data and unmapped answer
  always_comb begin
    mapped = 1'b1;
    prdata = '0;
    unique case (paddr)
      mqs_pkg::REG_CTRL: prdata = {27'h0, ctrl};
      mqs_pkg::REG_STATUS: prdata = {28'h0, link.almostFullN, link.outputValidN, loadArmed, chainReady};
      mqs_pkg::REG_WQSEL: prdata = {26'h0, link.wrAddr};
      mqs_pkg::REG_RQSEL: prdata = {26'h0, link.rdAddr};
      mqs_pkg::REG_WDATA: prdata = link.wrData[31:0];
      mqs_pkg::REG_RDATA: prdata = link.rdDataOe ? link.rdData[31:0] : 32'h0;
      mqs_pkg::REG_READ: prdata = 32'h0;
      mqs_pkg::REG_INT_STAT: prdata = {28'h0, intStat};
      mqs_pkg::REG_INT_MASK: prdata = {28'h0, intMask};
      mqs_pkg::REG_SER_PAT: prdata = serPat;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;
endmodule
`default_nettype wire

// ### test/mqs_assertions.sv
// Checker for the link between controller end and queue device end.
// Assumes one device, number zero, on the link and a single clock.
`timescale 1ns/100ps
`default_nettype none
module mqs_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic masterResetN,
  input wire logic defaultModeSelect,
  input wire logic serialLoadEnableInN,
  input wire logic serialDataIn,
  input wire logic serialLoadEnableOutN,
  input wire logic serialDataOut,
  input wire logic wrSel,
  input wire logic wenN,
  input wire logic rdSel,
  input wire logic [mqs_pkg::ADDR_W-1:0] rdAddr,
  input wire logic renN,
  input wire logic outEnN,
  input wire logic [mqs_pkg::DATA_W-1:0] rdData,
  input wire logic rdDataOe,
  input wire logic outputValidN,
  input wire logic outputValidOe,
  input wire logic almostFullN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================
  // Helpers
  logic [mqs_pkg::LOAD_CNT_W-1:0] loadCnt;
  logic ownRd;
  // Serial bits counted while the device is still loading
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      loadCnt <= '0;
    end else if (!masterResetN) begin
      loadCnt <= '0;
    end else if (!serialLoadEnableInN && serialLoadEnableOutN) begin
      loadCnt <= loadCnt + 1'b1;
    end
  end
  // Read owner latched at each selection; only device zero exists
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ownRd <= 1'b0;
    end else if (rdSel) begin
      ownRd <= (rdAddr[5:3] == 3'h0);
    end
  end
  // ==========================================================
  // Sequences and properties
  sequence s_rsel;
    rdSel ##1 (!rdSel) [*2];
  endsequence
  sequence s_nsel;
    rdSel && rdAddr[2:0] == mqs_pkg::NULL_Q ##1 (!rdSel) [*2];
  endsequence
  property p_pass;
    !serialLoadEnableOutN |-> !serialLoadEnableInN && serialDataOut == serialDataIn;
  endproperty
  a_pass: assert property (p_pass) else $error("chain pass-through broken");
  property p_mode;
    !masterResetN && !defaultModeSelect ##1 masterResetN |-> serialLoadEnableOutN;
  endproperty
  a_mode: assert property (p_mode) else $error("serial mode came up configured");
  property p_len;
    $fell(serialLoadEnableOutN) && !defaultModeSelect |-> loadCnt == mqs_pkg::LOAD_BITS;
  endproperty
  a_len: assert property (p_len) else $error("load finished at wrong bit count");
  property p_quiet;
    serialLoadEnableOutN |-> !wrSel && !rdSel && wenN && renN;
  endproperty
  a_quiet: assert property (p_quiet) else $error("port strobe before configuration");
  property p_gap;
    rdSel |=> !rdSel;
  endproperty
  a_gap: assert property (p_gap) else $error("read selections too close");
  property p_owner;
    s_rsel |=> outputValidOe == ownRd;
  endproperty
  a_owner: assert property (p_owner) else $error("valid flag owner wrong after select");
  property p_null;
    s_nsel |=> outputValidN && $stable(rdData);
  endproperty
  a_null: assert property (p_null) else $error("null queue not seen as empty");
  property p_hold;
    masterResetN && renN && !outputValidN && !rdSel && !$past(rdSel) && !$past(rdSel, 2) |=> $stable(rdData);
  endproperty
  a_hold: assert property (p_hold) else $error("word moved with reads disabled");
  property p_oe;
    outEnN |-> !rdDataOe;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven with output enable off");
  property p_af;
    $fell(almostFullN) |-> !$past(wenN, 3) || $past(wrSel, 3);
  endproperty
  a_af: assert property (p_af) else $error("almost-full fell without write two cycles before");
endmodule
`default_nettype wire

// ### test/tb.sv
// Testbench: controller and device joined by the link, driven over APB.
// Assumes the design answers APB with the wait states its note gives.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, x, g) begin testsRun++; if ((g) !== (x)) begin fails++; $display("ERROR %s exp %0h got %0h", nm, x, g); end end
module tb;
  logic sys_clk = 1'b0;
  logic arst_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int fails = 0;
  int testsRun = 0;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  mqs_if mqs_if_i ();
  mqs_ctrl mqs_ctrl_i (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(mqs_if_i));
  mqs_device mqs_device_i (.sys_clk(sys_clk), .arst_n(arst_n), .link(mqs_if_i));
  mqs_assertions mqs_assertions_i (.sys_clk(sys_clk), .arst_n(arst_n), .masterResetN(mqs_if_i.masterResetN),
    .defaultModeSelect(mqs_if_i.defaultModeSelect), .serialLoadEnableInN(mqs_if_i.serialLoadEnableInN),
    .serialDataIn(mqs_if_i.serialDataIn), .serialLoadEnableOutN(mqs_if_i.serialLoadEnableOutN),
    .serialDataOut(mqs_if_i.serialDataOut), .wrSel(mqs_if_i.wrSel), .wenN(mqs_if_i.wenN), .rdSel(mqs_if_i.rdSel),
    .rdAddr(mqs_if_i.rdAddr), .renN(mqs_if_i.renN), .outEnN(mqs_if_i.outEnN), .rdData(mqs_if_i.rdData),
    .rdDataOe(mqs_if_i.rdDataOe), .outputValidN(mqs_if_i.outputValidN), .outputValidOe(mqs_if_i.outputValidOe),
    .almostFullN(mqs_if_i.almostFullN));
  // ==========================================================
  // Clock
  always #4 sys_clk = ~sys_clk;
  // ==========================================================
  // Bus tasks; requests held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Writes settle a few cycles so link strobes land before the next look
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    idle(4);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, x & m, q & m)
  endtask
  task automatic results;
    $display("Comparisons %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog: tests need under two thousand cycles
  initial begin
    repeat (8000) @(posedge sys_clk);
    fails++;
    results();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    logic e;
    int n;
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    wr(mqs_pkg::REG_SER_PAT, 32'hC3A5_0F96);
    wr(mqs_pkg::REG_CTRL, 32'h0);
    wr(mqs_pkg::REG_WDATA, 32'h1);
    chk(mqs_pkg::REG_INT_STAT, 32'h8, 32'h8, "refused early write");
    wr(mqs_pkg::REG_CTRL, 32'h4);
    idle(285);
    chk(mqs_pkg::REG_STATUS, 32'h1, 32'h0, "ready too soon");
    n = 0;
    do begin
      apb(1'b0, mqs_pkg::REG_STATUS, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b1 && n < 40);
    `CHK("chain ready", 1'b1, q[0])
    `CHK("enable through", 1'b0, mqs_if_i.serialLoadEnableOutN)
    `CHK("data through", mqs_if_i.serialDataIn, mqs_if_i.serialDataOut)
    apb(1'b0, mqs_pkg::REG_INT_STAT, 32'h0, q, e);
    wr(mqs_pkg::REG_INT_MASK, 32'h2);
    wr(mqs_pkg::REG_WQSEL, 32'h0);
    wr(mqs_pkg::REG_RQSEL, 32'h0);
    wr(mqs_pkg::REG_WDATA, 32'h11);
    chk(mqs_pkg::REG_RDATA, ALL, 32'h11, "first word");
    `CHK("irq raised", 1'b1, irq)
    chk(mqs_pkg::REG_STATUS, 32'h4, 32'h0, "valid low");
    chk(mqs_pkg::REG_INT_STAT, 32'h2, 32'h2, "valid event");
    `CHK("irq cleared", 1'b0, irq)
    wr(mqs_pkg::REG_WDATA, 32'h22);
    wr(mqs_pkg::REG_WDATA, 32'h33);
    chk(mqs_pkg::REG_RDATA, ALL, 32'h11, "held word");
    wr(mqs_pkg::REG_READ, 32'h0);
    chk(mqs_pkg::REG_RDATA, ALL, 32'h22, "second word");
    wr(mqs_pkg::REG_READ, 32'h0);
    wr(mqs_pkg::REG_READ, 32'h0);
    chk(mqs_pkg::REG_RDATA, ALL, 32'h33, "last word kept");
    chk(mqs_pkg::REG_STATUS, 32'h4, 32'h4, "empty flag");
    wr(mqs_pkg::REG_WQSEL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(mqs_pkg::REG_WDATA, 32'h44 + 32'(i));
    end
    wr(mqs_pkg::REG_WQSEL, 32'h0);
    wr(mqs_pkg::REG_WDATA, 32'h66);
    wr(mqs_pkg::REG_WDATA, 32'h77);
    wr(mqs_pkg::REG_RQSEL, 32'h1);
    chk(mqs_pkg::REG_RDATA, ALL, 32'h44, "new queue word");
    wr(mqs_pkg::REG_RQSEL, 32'h0);
    chk(mqs_pkg::REG_RDATA, ALL, 32'h45, "old queue pop");
    chk(mqs_pkg::REG_STATUS, 32'h4, 32'h4, "drained queue");
    // Back to back selections keep the spacing
    apb(1'b1, mqs_pkg::REG_RQSEL, 32'h1, q, e);
    apb(1'b1, mqs_pkg::REG_RQSEL, {29'h0, mqs_pkg::NULL_Q}, q, e);
    idle(4);
    chk(mqs_pkg::REG_STATUS, 32'h4, 32'h4, "null empty");
    apb(1'b0, mqs_pkg::REG_RDATA, 32'h0, q, e);
    wr(mqs_pkg::REG_READ, 32'h0);
    chk(mqs_pkg::REG_RDATA, ALL, q, "null keeps word");
    wr(mqs_pkg::REG_RQSEL, 32'h08);
    `CHK("valid floated", 1'b0, mqs_if_i.outputValidOe)
    chk(mqs_pkg::REG_RDATA, ALL, 32'h0, "bus floated");
    wr(mqs_pkg::REG_RQSEL, 32'h0);
    `CHK("valid driven", 1'b1, mqs_if_i.outputValidOe)
    wr(mqs_pkg::REG_CTRL, 32'h8);
    `CHK("bus off", 1'b0, mqs_if_i.rdDataOe)
    `CHK("flag kept", 1'b1, mqs_if_i.outputValidOe)
    wr(mqs_pkg::REG_CTRL, 32'h0);
    chk(mqs_pkg::REG_INT_STAT, 32'h2, 32'h2, "valid fell again");
    wr(mqs_pkg::REG_WQSEL, 32'h2);
    for (int i = 0; i < 11; i++) begin
      wr(mqs_pkg::REG_WDATA, 32'(i));
    end
    chk(mqs_pkg::REG_STATUS, 32'h8, 32'h8, "below level");
    wr(mqs_pkg::REG_WDATA, 32'hB);
    chk(mqs_pkg::REG_STATUS, 32'h8, 32'h0, "almost full");
    `CHK("irq masked", 1'b0, irq)
    wr(mqs_pkg::REG_WQSEL, 32'h3);
    chk(mqs_pkg::REG_STATUS, 32'h8, 32'h8, "flag of new queue");
    wr(mqs_pkg::REG_WQSEL, 32'h0A);
    `CHK("full flag floated", 1'b0, mqs_if_i.almostFullOe)
    wr(mqs_pkg::REG_WQSEL, 32'h2);
    `CHK("full flag driven", 1'b1, mqs_if_i.almostFullOe)
    chk(mqs_pkg::REG_STATUS, 32'h8, 32'h0, "flag back");
    chk(mqs_pkg::REG_INT_STAT, 32'h4, 32'h4, "full event");
    apb(1'b0, 8'h40, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
    results();
  end
endmodule
`default_nettype wire
